/* logic/pch_pkg.sv */
// constants, field layouts and carrier types of the configuration header slice
// assumes a single ref_clk domain; no surrounding bus beyond configuration cycles and received bus phases
package pch_pkg;

  // byte offsets of the header fields
  localparam logic [7:0] OFS_MAKER = 8'h00;
  localparam logic [7:0] OFS_PART = 8'h02;
  localparam logic [7:0] OFS_COMMAND = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h06;
  localparam logic [7:0] OFS_REVISION = 8'h08;

  // dword index of a configuration access
  localparam int IDX_W = 6;
  localparam logic [IDX_W-1:0] IDX_ID = IDX_W'(OFS_MAKER >> 2);
  localparam logic [IDX_W-1:0] IDX_CMDSTAT = IDX_W'(OFS_COMMAND >> 2);
  localparam logic [IDX_W-1:0] IDX_REV = IDX_W'(OFS_REVISION >> 2);

  // command bits
  localparam int CMD_MEM = 1;
  localparam int CMD_MASTER = 2;
  localparam int CMD_PERR = 6;
  localparam int CMD_SERR = 8;
  localparam logic [15:0] CMD_MASK = 16'h0146;
  localparam logic [15:0] CMD_RESET = 16'h0000;

  // status bits
  localparam int ST_DPR = 8;
  localparam int ST_DEVSEL_LO = 9;
  localparam int ST_TABORT = 12;
  localparam int ST_SERR_DRIVEN = 13;
  localparam int ST_SYSERR = 14;
  localparam int ST_DETPAR = 15;
  localparam logic [15:0] ST_STICKY_MASK = 16'hF100;
  localparam logic [15:0] ST_RESET = 16'h0000;
  localparam logic [1:0] DEVSEL_SLOW = 2'h2;

  localparam int ST_HALF = 16;

  typedef struct packed {
    logic valid;
    logic write;
    logic [IDX_W-1:0] index;
    logic [3:0] byteEn;
    logic [31:0] wdata;
  } pch_cfg_req_t;

  typedef struct packed {
    logic valid;
    logic isAddr;
    logic masterRead;
    logic [31:0] ad;
    logic [3:0] cben;
  } pch_bus_phase_t;

endpackage : pch_pkg

/* logic/pch_parity_check.sv */
// even parity check of one address or data phase against the lagging parity bit
// assumes phase.valid marks a phase received by this device, par one clock later
`timescale 1ns/1ps
module pch_parity_check
  import pch_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire pch_bus_phase_t phase,
  input wire logic parIn,
  output logic parFault,
  output logic faultIsAddr,
  output logic faultMasterRead
);

  logic held;
  logic heldOdd;
  logic heldAddr;
  logic heldRead;
  logic next_held;
  logic next_heldOdd;
  logic next_heldAddr;
  logic next_heldRead;

  always_comb begin
    next_held = phase.valid;
    next_heldOdd = ^{phase.ad, phase.cben};
    next_heldAddr = phase.isAddr;
    next_heldRead = phase.masterRead;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      held <= 1'b0;
      heldOdd <= 1'b0;
      heldAddr <= 1'b0;
      heldRead <= 1'b0;
    end else begin
      held <= next_held;
      heldOdd <= next_heldOdd;
      heldAddr <= next_heldAddr;
      heldRead <= next_heldRead;
    end
  end

  // par arrives one clock after its phase, so the check runs in that clock
  always_comb begin
    parFault = held && (heldOdd ^ parIn);
    faultIsAddr = heldAddr;
    faultMasterRead = heldRead;
  end

endmodule : pch_parity_check

/* logic/pch_config_regs.sv */
// identification, command and status registers of a type-zero configuration header
// assumes configuration cycles already decoded into one request per dword, and
// bus phases received by this device presented with their address/data and command
`timescale 1ns/1ps
module pch_config_regs
  import pch_pkg::*;
#(
  parameter logic [15:0] MAKER_CODE_PARAMETER = 16'h1A2B, // value arbitrary
  parameter logic [15:0] PART_CODE_PARAMETER = 16'h00C3, // value arbitrary
  parameter logic [7:0] REVISION_PARAMETER = 8'h05, // value arbitrary
  parameter int AD_WIDTH = 32
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire pch_cfg_req_t cfgReq,
  output logic cfgAck,
  output logic [31:0] cfgRdata,
  input wire pch_bus_phase_t phase,
  input wire logic parIn,
  input wire logic peerPerrSeen,
  input wire logic targetAbortEvt,
  input wire logic sysErrEvt,
  input wire logic dmaBusReq,
  input wire logic memDecodeHit,
  output logic memRespond,
  output logic reqN,
  output logic perrPinOut,
  output logic perrOeN,
  output logic serrPinOut,
  output logic serrOeN
);

  ////////////////////////////////////////////////////////////////////////////
  // parameter check

  generate
    if (AD_WIDTH != 32) begin : gBadWidth
      $error("only a 32-bit address/data path is supported");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // parity checker

  logic parFault;
  logic faultIsAddr;
  logic faultMasterRead;

  pch_parity_check pch_parity_check_i (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .phase(phase),
    .parIn(parIn),
    .parFault(parFault),
    .faultIsAddr(faultIsAddr),
    .faultMasterRead(faultMasterRead)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic [15:0] command;
  logic [15:0] status;
  logic [15:0] next_command;
  logic [15:0] next_status;
  logic [15:0] setVec;
  logic [15:0] clrVec;
  logic cmdWrite;
  logic [15:0] cmdWdata;

  always_comb begin
    cmdWrite = cfgReq.valid && cfgReq.write && (cfgReq.index == IDX_CMDSTAT);
    cmdWdata = cfgReq.wdata[ST_HALF-1:0];
    next_command = command;
    if (cmdWrite) begin
      for (int b = 0; b < 2; b++) begin
        if (cfgReq.byteEn[b]) begin
          next_command[8*b +: 8] = cmdWdata[8*b +: 8] & CMD_MASK[8*b +: 8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // error pins and status events

  logic perrDrive;
  logic perrRelease;
  logic serrDrive;
  logic next_perrDrive;
  logic next_perrRelease;
  logic next_serrDrive;
  logic dataFault;
  logic addrFault;

  always_comb begin
    dataFault = parFault && !faultIsAddr;
    addrFault = parFault && faultIsAddr;
    // lands in the second clock after the phase
    next_perrDrive = dataFault && command[CMD_PERR];
    next_serrDrive = (addrFault || sysErrEvt) && command[CMD_SERR];
    // sustained pin: one clock driven high before release
    next_perrRelease = perrDrive && !next_perrDrive;
  end

  always_comb begin
    setVec = '0;
    setVec[ST_DPR] = command[CMD_PERR]
                     && ((dataFault && faultMasterRead) || peerPerrSeen);
    setVec[ST_TABORT] = targetAbortEvt;
    setVec[ST_SERR_DRIVEN] = next_serrDrive;
    setVec[ST_SYSERR] = sysErrEvt || addrFault;
    setVec[ST_DETPAR] = parFault;
    clrVec = '0;
    if (cmdWrite) begin
      for (int b = 0; b < 2; b++) begin
        if (cfgReq.byteEn[b + 2]) begin
          clrVec[8*b +: 8] = cfgReq.wdata[ST_HALF + 8*b +: 8];
        end
      end
    end
    // a fresh event wins over a clear in the same clock
    next_status = ((status & ~clrVec) | setVec) & ST_STICKY_MASK;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      command <= CMD_RESET;
      status <= ST_RESET;
      perrDrive <= 1'b0;
      perrRelease <= 1'b0;
      serrDrive <= 1'b0;
    end else begin
      command <= next_command;
      status <= next_status;
      perrDrive <= next_perrDrive;
      perrRelease <= next_perrRelease;
      serrDrive <= next_serrDrive;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration read path and pin outputs

  logic [31:0] next_cfgRdata;
  logic next_cfgAck;
  logic next_memRespond;
  logic next_reqN;
  logic [15:0] statusView;

  always_comb begin
    statusView = status;
    statusView[ST_DEVSEL_LO +: 2] = DEVSEL_SLOW;
    next_cfgAck = cfgReq.valid;
    next_cfgRdata = '0;
    if (cfgReq.valid && !cfgReq.write) begin
      unique case (cfgReq.index)
        IDX_ID: next_cfgRdata = {PART_CODE_PARAMETER, MAKER_CODE_PARAMETER};
        IDX_CMDSTAT: next_cfgRdata = {statusView, command};
        IDX_REV: next_cfgRdata = {24'h000000, REVISION_PARAMETER};
        default: next_cfgRdata = '0;
      endcase
    end
    // target and master gating follow the live command bits
    next_memRespond = memDecodeHit && next_command[CMD_MEM];
    next_reqN = !(dmaBusReq && next_command[CMD_MASTER]);
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cfgAck <= 1'b0;
      cfgRdata <= '0;
      memRespond <= 1'b0;
      reqN <= 1'b1;
      perrPinOut <= 1'b1;
      perrOeN <= 1'b1;
      serrPinOut <= 1'b1;
      serrOeN <= 1'b1;
    end else begin
      cfgAck <= next_cfgAck;
      cfgRdata <= next_cfgRdata;
      memRespond <= next_memRespond;
      reqN <= next_reqN;
      perrPinOut <= !next_perrDrive;
      perrOeN <= !(next_perrDrive || next_perrRelease);
      // open drain: only ever pulls low
      serrPinOut <= !next_serrDrive;
      serrOeN <= !next_serrDrive;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  logic idRead;
  logic csRead;
  logic revRead;
  assign idRead = cfgReq.valid && !cfgReq.write && cfgReq.index == IDX_ID;
  assign csRead = cfgReq.valid && !cfgReq.write && cfgReq.index == IDX_CMDSTAT;
  assign revRead = cfgReq.valid && !cfgReq.write && cfgReq.index == IDX_REV;

  AST_ID_READ: assert property (
    idRead |=> cfgAck && cfgRdata == {PART_CODE_PARAMETER, MAKER_CODE_PARAMETER})
    else $error("identification read returned wrong value");

  AST_REV_READ: assert property (
    revRead |=> cfgRdata[7:0] == REVISION_PARAMETER && cfgRdata[31:8] == '0)
    else $error("revision read returned wrong value");

  AST_MEM_GATE: assert property (
    memRespond |-> command[CMD_MEM] && $past(memDecodeHit))
    else $error("memory answer without memory enable");

  AST_REQ_GATE: assert property (
    !reqN |-> command[CMD_MASTER] && $past(dmaBusReq))
    else $error("bus request without master enable");

  AST_PERR_GATE: assert property (
    !perrOeN && !perrPinOut |-> $past(command[CMD_PERR]) && $past(dataFault))
    else $error("parity error pin driven while disabled");

  AST_SERR_GATE: assert property (
    !serrOeN |-> $past(command[CMD_SERR]))
    else $error("system error pin driven while disabled");

  AST_W1C: assert property (
    cmdWrite && cfgReq.byteEn[3:2] == 2'h3 && cfgReq.wdata[31:16] == 16'hFFFF
    && setVec == '0 |=> (status & ST_STICKY_MASK) == '0)
    else $error("write of ones did not clear status");

  AST_NO_SET: assert property (
    $rose(status[ST_TABORT]) |-> $past(targetAbortEvt))
    else $error("target abort bit set without event");

  AST_RESET_ZERO: assert property (
    disable iff (1'b0) $past(sys_rst) |-> status == ST_RESET)
    else $error("status not zero after reset");

  AST_DPR_GATE: assert property (
    $rose(status[ST_DPR]) |-> $past(command[CMD_PERR]))
    else $error("data parity reported set while reporting off");

  AST_DEVSEL: assert property (
    csRead |=> cfgRdata[ST_HALF + ST_DEVSEL_LO +: 2] == DEVSEL_SLOW)
    else $error("device select timing not slow");

  AST_TABORT_HOLD: assert property (
    targetAbortEvt |=> status[ST_TABORT])
    else $error("target abort event not recorded");

  AST_SERR_STATUS: assert property (
    $fell(serrOeN) |-> status[ST_SERR_DRIVEN])
    else $error("system error drive not recorded");

  AST_DETPAR: assert property (
    parFault |=> status[ST_DETPAR])
    else $error("detected parity error not recorded");

  AST_PERR_LAG: assert property (
    phase.valid && !phase.isAddr && command[CMD_PERR]
    ##1 (^{$past(phase.ad), $past(phase.cben), parIn}) && command[CMD_PERR]
    |=> !perrOeN && !perrPinOut)
    else $error("parity error pin not two clocks after the phase");

  AST_UNUSED_ZERO: assert property (
    (command & ~CMD_MASK) == '0 && (status & ~ST_STICKY_MASK) == '0)
    else $error("unused command or status bit set");

  AST_PART_READ: assert property (
    idRead |=> cfgRdata[ST_HALF +: ST_HALF] == PART_CODE_PARAMETER)
    else $error("part identifier read returned wrong value");

  AST_MEM_ON: assert property (
    memDecodeHit && command[CMD_MEM] && !cmdWrite |=> memRespond)
    else $error("enabled memory hit not answered");

  AST_REQ_ON: assert property (
    dmaBusReq && command[CMD_MASTER] && !cmdWrite |=> !reqN)
    else $error("enabled bus request not raised");

  AST_PERR_START: assert property (
    $fell(perrOeN) |-> !perrPinOut)
    else $error("parity error pin enabled without a low report");

  AST_PERR_HOLD: assert property (
    !perrOeN && !perrPinOut |=> !perrOeN)
    else $error("parity error pin released while low");

  AST_ADDR_NO_PERR: assert property (
    addrFault |=> perrPinOut)
    else $error("address parity error reported on parity error pin");

  AST_W1C_KEEP: assert property (
    cmdWrite && cfgReq.wdata[ST_HALF +: ST_HALF] == '0 && setVec == '0 |=> $stable(status))
    else $error("status changed on a write of zeros");

  AST_CLR_ALONE: assert property (
    cmdWrite && cfgReq.byteEn[3] && setVec == '0
    && cfgReq.wdata[ST_HALF +: ST_HALF] == (16'h0001 << ST_SYSERR)
    |=> !status[ST_SYSERR] && ((status ^ $past(status)) & ~(16'h0001 << ST_SYSERR)) == '0)
    else $error("system error clear disturbed other status bits");

  AST_DPR_STATUS: assert property (
    dataFault && faultMasterRead && command[CMD_PERR] |=> status[ST_DPR])
    else $error("master read parity error not reported in status");

  AST_TABORT_STICKY: assert property (
    status[ST_TABORT] && !(cmdWrite && cfgReq.byteEn[3] && cfgReq.wdata[ST_HALF + ST_TABORT])
    |=> status[ST_TABORT])
    else $error("target abort bit lost without a clear");

  AST_SERR_LAG: assert property (
    phase.valid && phase.isAddr && command[CMD_SERR]
    ##1 (^{$past(phase.ad), $past(phase.cben), parIn}) && command[CMD_SERR]
    |=> !serrOeN && !serrPinOut)
    else $error("system error pin not two clocks after the address phase");

  COV_MEM_ON: cover property (cmdWrite ##1 memRespond);
  COV_PERR: cover property ($fell(perrOeN) ##1 perrPinOut && !perrOeN ##1 perrOeN);
  COV_CLEAR_RACE: cover property (cmdWrite && clrVec[ST_TABORT] && targetAbortEvt);
  COV_SERR: cover property ($fell(serrOeN));
  COV_ADDR_FAULT: cover property (addrFault ##1 !serrOeN);

endmodule : pch_config_regs

/* tb/pch_host_model.sv */
// host bridge side: issues decoded configuration dword accesses
// assumes the one-cycle strobe with its answer one clock later
`timescale 1ns/1ps
module pch_host_model
  import pch_pkg::*;
(
  input wire logic ref_clk,
  output pch_cfg_req_t cfgReq,
  input wire logic cfgAck,
  input wire logic [31:0] cfgRdata
);
  initial cfgReq = '{1'b0, 1'b0, '0, 4'h0, 32'hA5A5A5A5};

  task automatic access(input logic wr, input logic [IDX_W-1:0] idx, input logic [3:0] be,
      input logic [31:0] wd, output logic [31:0] rd, output logic ack);
    @(posedge ref_clk);
    #1;
    cfgReq = '{1'b1, wr, idx, be, wd};
    @(posedge ref_clk);
    #1;
    ack = cfgAck;
    rd = cfgRdata;
    // released qualifiers move, so a stale value cannot pass
    cfgReq = '{1'b0, ~wr, ~idx, ~be, ~wd};
  endtask : access
endmodule : pch_host_model

/* tb/pch_config_regs_test.sv */
// self-checking bench for the identification, command and status registers
// assumes pch_host_model drives the configuration port
`timescale 1ns/1ps
module pch_config_regs_test
  import pch_pkg::*;
;
  localparam logic [15:0] MAKER = 16'h5E71; // value arbitrary
  localparam logic [15:0] PART = 16'h0C0D; // value arbitrary
  localparam logic [7:0] REV = 8'h3A; // value arbitrary
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  pch_cfg_req_t cfgReq;
  logic cfgAck, memRespond, reqN, perrPinOut, perrOeN, serrPinOut, serrOeN;
  logic [31:0] cfgRdata;
  pch_bus_phase_t phase = '0;
  logic parIn = 1'b0;
  logic peerPerrSeen = 1'b0;
  logic targetAbortEvt = 1'b0;
  logic sysErrEvt = 1'b0;
  logic dmaBusReq = 1'b0;
  logic memDecodeHit = 1'b0;
  int err_count = 0;
  int num_checks = 0;

  always #5 ref_clk = ~ref_clk;

  pch_config_regs #(.MAKER_CODE_PARAMETER(MAKER), .PART_CODE_PARAMETER(PART),
    .REVISION_PARAMETER(REV)) pch_config_regs_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .cfgReq(cfgReq), .cfgAck(cfgAck), .cfgRdata(cfgRdata), .phase(phase), .parIn(parIn),
    .peerPerrSeen(peerPerrSeen), .targetAbortEvt(targetAbortEvt), .sysErrEvt(sysErrEvt),
    .dmaBusReq(dmaBusReq), .memDecodeHit(memDecodeHit), .memRespond(memRespond),
    .reqN(reqN), .perrPinOut(perrPinOut), .perrOeN(perrOeN), .serrPinOut(serrPinOut),
    .serrOeN(serrOeN));
  pch_host_model pch_host_model_i (.ref_clk(ref_clk), .cfgReq(cfgReq), .cfgAck(cfgAck),
    .cfgRdata(cfgRdata));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic rdw(input logic [IDX_W-1:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    logic ack;
    pch_host_model_i.access(1'b0, idx, 4'hF, 32'h0, rd, ack);
    chk(ack, 1, "read ack");
    chk(rd, exp, "read data");
  endtask : rdw

  task automatic wrw(input logic [IDX_W-1:0] idx, input logic [3:0] be, input logic [31:0] wd);
    logic [31:0] rd;
    logic ack;
    pch_host_model_i.access(1'b1, idx, be, wd, rd, ack);
    chk(ack, 1, "write ack");
  endtask : wrw

  task automatic sendPhase(input logic ia, input logic mr, input logic [31:0] ad,
      input logic [3:0] cb, input logic good);
    tick();
    phase = '{1'b1, ia, mr, ad, cb};
    tick();
    phase = '{1'b0, ~ia, ~mr, ~ad, ~cb};
    parIn = ^{ad, cb} ^ ~good;
    tick();
  endtask : sendPhase

  task automatic sysErr(input logic [31:0] expCnt);
    int n;
    n = 0;
    tick();
    sysErrEvt = 1'b1;
    tick();
    sysErrEvt = 1'b0;
    for (int i = 0; i < 5; i++) begin
      n += (serrOeN === 1'b0 && serrPinOut === 1'b0);
      tick();
    end
    chk(n, expCnt, "serr cycles");
  endtask : sysErr

  ////////////////////////////////////////////////////////////////////////////////
  task automatic testRegs();
    chk({memRespond, reqN, perrOeN, serrOeN}, 4'h7, "reset pins");
    rdw(1, 32'h0400_0000);
    rdw(0, {PART, MAKER});
    rdw(2, {24'h0, REV});
    wrw(0, 4'hF, 32'hFFFF_FFFF);
    wrw(2, 4'hF, 32'h0);
    rdw(0, {PART, MAKER});
    rdw(2, {24'h0, REV});
    rdw(3, 32'h0);
    wrw(1, 4'hF, 32'hFFFF_FFFF);
    rdw(1, 32'h0400_0146);
    wrw(1, 4'h1, 32'h0);
    rdw(1, 32'h0400_0100);
    wrw(1, 4'h2, 32'h0);
    rdw(1, 32'h0400_0000);
    $display("test regs done");
  endtask : testRegs

  task automatic testGates();
    memDecodeHit = 1'b1;
    dmaBusReq = 1'b1;
    wrw(1, 4'h3, 32'h0002);
    chk({memRespond, reqN}, 2'h3, "mem only");
    wrw(1, 4'h3, 32'h0006);
    chk({memRespond, reqN}, 2'h2, "mem and master");
    tick();
    chk({memRespond, reqN}, 2'h2, "held while enabled");
    dmaBusReq = 1'b0;
    tick();
    chk(reqN, 1, "no request");
    wrw(1, 4'h3, 32'h0);
    chk(memRespond, 0, "mem off");
    memDecodeHit = 1'b0;
    $display("test gates done");
  endtask : testGates

  task automatic testParity();
    sendPhase(1'b0, 1'b1, 32'h1, 4'h0, 1'b0);
    chk(perrOeN, 1, "perr gated");
    rdw(1, 32'h8400_0000);
    wrw(1, 4'hC, 32'hFFFF_0000);
    sendPhase(1'b0, 1'b1, 32'h7, 4'h3, 1'b1);
    rdw(1, 32'h0400_0000);
    wrw(1, 4'h3, 32'h0040);
    sendPhase(1'b0, 1'b1, 32'h3, 4'h1, 1'b0);
    chk({perrOeN, perrPinOut}, 2'h0, "perr low");
    tick();
    chk({perrOeN, perrPinOut}, 2'h1, "perr high");
    tick();
    chk(perrOeN, 1, "perr released");
    rdw(1, 32'h8500_0040);
    wrw(1, 4'h8, 32'h0100_0000);
    rdw(1, 32'h8400_0040);
    $display("test parity done");
  endtask : testParity

  task automatic testErrors();
    wrw(1, 4'hF, 32'hFFFF_0100);
    sysErr(1);
    rdw(1, 32'h6400_0100);
    wrw(1, 4'h8, 32'h4000_0000);
    rdw(1, 32'h2400_0100);
    tick();
    targetAbortEvt = 1'b1;
    tick();
    targetAbortEvt = 1'b0;
    wrw(1, 4'hC, 32'h0);
    rdw(1, 32'h3400_0100);
    // clear and a fresh abort land on the same edge
    fork
      wrw(1, 4'hC, 32'hFFFF_0000);
      begin
        tick();
        targetAbortEvt = 1'b1;
        tick();
        targetAbortEvt = 1'b0;
      end
    join
    rdw(1, 32'h1400_0100);
    wrw(1, 4'hF, 32'hFFFF_0040);
    sysErr(0);
    tick();
    peerPerrSeen = 1'b1;
    tick();
    peerPerrSeen = 1'b0;
    rdw(1, 32'h4500_0040);
    wrw(1, 4'hF, 32'hFFFF_0140);
    sendPhase(1'b1, 1'b0, 32'h1, 4'h0, 1'b0);
    chk({serrOeN, serrPinOut, perrOeN}, 3'h1, "address fault pins");
    rdw(1, 32'hE400_0140);
    wrw(1, 4'hC, 32'hFFFF_0000);
    sendPhase(1'b0, 1'b0, 32'h1, 4'h0, 1'b0);
    chk({perrOeN, perrPinOut}, 2'h0, "target write perr");
    rdw(1, 32'h8400_0140);
    $display("test errors done");
  endtask : testErrors

  task automatic testReset();
    sys_rst = 1'b1;
    tick();
    tick();
    sys_rst = 1'b0;
    chk({memRespond, reqN, perrOeN, serrOeN}, 4'h7, "pins after reset");
    rdw(1, 32'h0400_0000);
    $display("test reset done");
  endtask : testReset

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    testRegs();
    testGates();
    testParity();
    testErrors();
    testReset();
    summarize();
  end

  // the tests need about 125 clocks; sixteen times that means a hang
  initial begin
    #20000;
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize();
  end
endmodule : pch_config_regs_test
